// ---- src/bcdc_defs.svh ----
`ifndef BCDC_DEFS_SVH
`define BCDC_DEFS_SVH

// count range
`define BCDC_COUNT_LAST      8'h99
`define BCDC_COUNT_ZERO      8'h00
// digit limits
`define BCDC_DIGIT_LAST      4'h9
`define BCDC_DIGIT_FOUR      4'h4
// monitor field positions
`define BCDC_TENS_MSB        7
`define BCDC_TENS_LSB        4
`define BCDC_UNITS_MSB       3
`define BCDC_UNITS_LSB       0
// internal oscillator rate
`define BCDC_SYS_HZ          200000000
`define BCDC_OSC_HZ          1000000
`define BCDC_OSC_DIV         (`BCDC_SYS_HZ / `BCDC_OSC_HZ)
// step source settings
`define BCDC_ADV_STEPS       16'h0010

`endif

// ---- src/bcdc_pkg.sv ----
package bcdc_pkg;

    // logic mode of the console
    typedef enum logic [1:0]
    {
        BCDC_MODE_LOAD = 2'b00,
        BCDC_MODE_RUN  = 2'b01,
        BCDC_MODE_STOP = 2'b10
    } bcdc_mode_t;

    // two-digit bcd value
    typedef struct packed
    {
        logic [3:0] tens;
        logic [3:0] units;
    } bcdc_value_t;

    // multiple-form carry taps
    typedef struct packed
    {
        logic divTwoTap;
        logic divFiveTap;
        logic divTenTap;
        logic divTwentyTap;
        logic divFiftyTap;
        logic hundredCountCarry;
    } bcdc_taps_t;

endpackage

// ---- src/bcdc_counter.sv ----
`include "bcdc_defs.svh"
`timescale 1ns/100ps
`default_nettype none

module bcdc_counter
    import bcdc_pkg::*;
#(
    parameter int OSC_DIV   = `BCDC_OSC_DIV,
    parameter int ADV_STEPS = `BCDC_ADV_STEPS
)
(
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst_b,
    // logic system clock selection
    input  wire logic        extClockSelect,
    input  wire logic        extClock,
    // console logic mode
    input  wire bcdc_mode_t  logicMode,
    input  wire logic        singleStep,
    input  wire logic        advanceStep,
    // variable form controls
    input  wire logic        varEnable,
    input  wire logic        varCarryIn,
    input  wire logic        varZero,
    input  wire logic        thumbwheelInhibit,
    input  wire bcdc_value_t thumbwheel,
    input  wire bcdc_value_t patchedValue,
    // variable form outputs
    output logic             selectableCarryOut,
    output logic             varHundredCarry,
    output bcdc_value_t      monitor,
    // multiple form controls
    input  wire logic        mulEnable,
    input  wire logic        mulCarryIn,
    input  wire logic        mulZero,
    // multiple form outputs
    output bcdc_taps_t       taps
);

    initial
    begin
        if (OSC_DIV < 2 || OSC_DIV > 65536 ||
            ADV_STEPS < 1 || ADV_STEPS > 65535)
            $error("bcdc_counter: bad parameter");
    end

    // ------------------------------------------------------------
    // functions
    // ------------------------------------------------------------
    function automatic bcdc_value_t bcdInc(input bcdc_value_t v);
        bcdc_value_t r;
        r = v;
        if (v.units == `BCDC_DIGIT_LAST)
        begin
            r.units = 4'h0;
            r.tens  = (v.tens == `BCDC_DIGIT_LAST) ? 4'h0 : v.tens + 4'h1;
        end
        else
        begin
            r.units = v.units + 4'h1;
        end
        return r;
    endfunction

    function automatic bcdc_value_t nextCount(
        input bcdc_value_t v,
        input logic        tick,
        input logic        en,
        input logic        ci,
        input logic        zero,
        input logic        load,
        input logic        adv);
        bcdc_value_t r;
        r = v;
        if (load)
            r = `BCDC_COUNT_ZERO;
        else if (tick && zero && adv)
            r = `BCDC_COUNT_ZERO;
        else if (tick && en && ci && adv)
            r = bcdInc(v);
        return r;
    endfunction

    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    logic [1:0] extSync;
    logic       extPrev;
    logic [1:0] stepSync;
    logic       stepPrev;
    logic [1:0] advSync;

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            extSync  <= 2'h0;
            extPrev  <= 1'b0;
            stepSync <= 2'h0;
            stepPrev <= 1'b0;
            advSync  <= 2'h0;
        end
        else
        begin
            extSync  <= {extSync[0], extClock};
            extPrev  <= extSync[1];
            stepSync <= {stepSync[0], singleStep};
            stepPrev <= stepSync[1];
            advSync  <= {advSync[0], advanceStep};
        end
    end

    // ------------------------------------------------------------
    // logic system clock tick
    // ------------------------------------------------------------
    logic [15:0] oscCnt;
    logic [15:0] next_oscCnt;
    logic        oscTick;
    logic        tick;

    always_comb
    begin
        oscTick     = (oscCnt == 16'(OSC_DIV - 1));
        next_oscCnt = oscTick ? 16'h0000 : oscCnt + 16'h0001;
        tick        = extClockSelect ? (extSync[1] && !extPrev)
                                     : oscTick;
    end

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
            oscCnt <= 16'h0000;
        else
            oscCnt <= next_oscCnt;
    end

    // ------------------------------------------------------------
    // stop mode step control
    // ------------------------------------------------------------
    logic        stepPending;
    logic        next_stepPending;
    logic [15:0] advLeft;
    logic [15:0] next_advLeft;
    logic        advActive;
    logic        running;

    always_comb
    begin
        advActive        = (advLeft != 16'h0000);
        running          = (logicMode == BCDC_MODE_RUN) ||
                           stepPending || advActive;
        next_stepPending = stepPending;
        next_advLeft     = advLeft;
        if (stepSync[1] && !stepPrev && logicMode == BCDC_MODE_STOP)
            next_stepPending = 1'b1;
        else if (tick)
            next_stepPending = 1'b0;
        if (logicMode != BCDC_MODE_STOP)
            next_advLeft = 16'h0000;
        else if (advSync[1] && !advActive)
            next_advLeft = 16'(ADV_STEPS);
        else if (tick && advActive)
            next_advLeft = advLeft - 16'h0001;
    end

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            stepPending <= 1'b0;
            advLeft     <= 16'h0000;
        end
        else
        begin
            stepPending <= next_stepPending;
            advLeft     <= next_advLeft;
        end
    end

    // ------------------------------------------------------------
    // counters
    // ------------------------------------------------------------
    bcdc_value_t varCount;
    bcdc_value_t next_varCount;
    bcdc_value_t mulCount;
    bcdc_value_t next_mulCount;
    logic        loadMode;

    always_comb
    begin
        loadMode      = (logicMode == BCDC_MODE_LOAD);
        next_varCount = nextCount(varCount, tick, varEnable, varCarryIn,
                                  varZero, loadMode, running);
        next_mulCount = nextCount(mulCount, tick, mulEnable, mulCarryIn,
                                  mulZero, loadMode, running);
    end

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            varCount <= `BCDC_COUNT_ZERO;
            mulCount <= `BCDC_COUNT_ZERO;
        end
        else
        begin
            varCount <= next_varCount;
            mulCount <= next_mulCount;
        end
    end

    // ------------------------------------------------------------
    // carry outputs
    // ------------------------------------------------------------
    bcdc_value_t selValue;
    bcdc_value_t selMinusOne;
    logic        atLast;

    always_comb
    begin
        selValue = thumbwheelInhibit ? patchedValue : thumbwheel;
        selMinusOne = selValue;
        if (selValue.units == 4'h0)
        begin
            selMinusOne.units = `BCDC_DIGIT_LAST;
            selMinusOne.tens  = (selValue.tens == 4'h0) ?
                                `BCDC_DIGIT_LAST : selValue.tens - 4'h1;
        end
        else
        begin
            selMinusOne.units = selValue.units - 4'h1;
        end
        selectableCarryOut = varCarryIn &&
                             (varCount == selMinusOne);
        varHundredCarry    = varCarryIn &&
                             (varCount == `BCDC_COUNT_LAST);
        monitor            = varCount;
        atLast             = (mulCount.units == `BCDC_DIGIT_LAST);
        taps.divTwoTap     = mulCarryIn && mulCount.units[0];
        taps.divFiveTap    = mulCarryIn && (atLast ||
                             mulCount.units == `BCDC_DIGIT_FOUR);
        taps.divTenTap     = mulCarryIn && atLast;
        taps.divTwentyTap  = mulCarryIn && atLast && mulCount.tens[0];
        taps.divFiftyTap   = mulCarryIn && atLast &&
                             (mulCount.tens == `BCDC_DIGIT_FOUR ||
                              mulCount.tens == `BCDC_DIGIT_LAST);
        taps.hundredCountCarry = mulCarryIn &&
                             (mulCount == `BCDC_COUNT_LAST);
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    sequence s_zeroReq;
        tick && varZero && running && !loadMode;
    endsequence
    property p_zeroWins;
        @(posedge clk_sys) disable iff (!rst_b)
        s_zeroReq |=> varCount == `BCDC_COUNT_ZERO;
    endproperty
    a_zeroWins: assert property (p_zeroWins)
        else $error("clear did not zero count");
    property p_load;
        @(posedge clk_sys) disable iff (!rst_b)
        loadMode |=> varCount == `BCDC_COUNT_ZERO &&
                     mulCount == `BCDC_COUNT_ZERO;
    endproperty
    a_load: assert property (p_load)
        else $error("load mode did not zero count");
    property p_hold;
        @(posedge clk_sys) disable iff (!rst_b)
        !(tick && running && (varZero || (varEnable && varCarryIn)))
            && !loadMode |=> $stable(varCount);
    endproperty
    a_hold: assert property (p_hold)
        else $error("count moved without enabled tick");
    property p_step;
        @(posedge clk_sys) disable iff (!rst_b)
        tick && varEnable && varCarryIn && running && !varZero && !loadMode
            && varCount != `BCDC_COUNT_LAST
            |=> varCount != $past(varCount);
    endproperty
    a_step: assert property (p_step)
        else $error("count did not advance");
    property p_wrap;
        @(posedge clk_sys) disable iff (!rst_b)
        tick && varEnable && varCarryIn && running && !varZero && !loadMode
            && varCount == `BCDC_COUNT_LAST
            |=> varCount == `BCDC_COUNT_ZERO;
    endproperty
    a_wrap: assert property (p_wrap)
        else $error("count did not wrap");
    property p_hundred;
        @(posedge clk_sys) disable iff (!rst_b)
        varHundredCarry |-> varCount == `BCDC_COUNT_LAST && varCarryIn;
    endproperty
    a_hundred: assert property (p_hundred)
        else $error("hundred carry at wrong count");
    property p_tapsOff;
        @(posedge clk_sys) disable iff (!rst_b)
        !mulCarryIn |-> taps == '0;
    endproperty
    a_tapsOff: assert property (p_tapsOff)
        else $error("tap active without carry in");
    property p_tenTap;
        @(posedge clk_sys) disable iff (!rst_b)
        taps.divTenTap |-> taps.divFiveTap && taps.divTwoTap;
    endproperty
    a_tenTap: assert property (p_tenTap)
        else $error("tap relation broken");
    property p_fifty;
        @(posedge clk_sys) disable iff (!rst_b)
        taps.divFiftyTap |-> taps.divTenTap && mulCount.units == 4'h9;
    endproperty
    a_fifty: assert property (p_fifty)
        else $error("fifty tap at wrong count");

endmodule

`default_nettype wire

// ---- verif/bcdc_patch_logic.sv ----
`timescale 1ns/100ps
`default_nettype none

module bcdc_patch_logic
    import bcdc_pkg::*;
(
    // clock and reset
    input  wire logic   clk_sys,
    input  wire logic   rst_b,
    // new levels wanted
    input  wire logic   reroll,
    // patched levels
    output bcdc_value_t patchedValue,
    output logic        mulEnable,
    output logic        mulCarryIn,
    output logic        mulZero
);
    integer seed = 55;

    always @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            patchedValue <= 8'h00;
            mulEnable    <= 1'b0;
            mulCarryIn   <= 1'b0;
            mulZero      <= 1'b0;
        end
        else if (reroll)
        begin
            patchedValue.tens  <= #1 4'({$random(seed)} % 10);
            patchedValue.units <= #1 4'({$random(seed)} % 10);
            mulEnable          <= #1 1'({$random(seed)} % 4 != 0);
            mulCarryIn         <= #1 1'({$random(seed)} % 4 != 0);
            mulZero            <= #1 1'({$random(seed)} % 128 == 0);
        end
    end
endmodule

`default_nettype wire

// ---- verif/bcdc_counter_test.sv ----
`timescale 1ns/100ps
`default_nettype none

module bcdc_counter_test
    import bcdc_pkg::*;
;
    logic        clk_sys = 1'b0;
    logic        rst_b = 1'b0;
    logic        extClockSelect = 1'b1;
    logic        extClock = 1'b0;
    bcdc_mode_t  logicMode = BCDC_MODE_RUN;
    logic        singleStep = 1'b0;
    logic        advanceStep = 1'b0;
    logic        varEnable = 1'b1;
    logic        varCarryIn = 1'b1;
    logic        varZero = 1'b0;
    logic        thumbwheelInhibit = 1'b0;
    bcdc_value_t thumbwheel = 8'h00;
    logic        reroll = 1'b0;
    bcdc_value_t patchedValue;
    bcdc_value_t monitor;
    logic        mulEnable;
    logic        mulCarryIn;
    logic        mulZero;
    logic        selectableCarryOut;
    logic        varHundredCarry;
    bcdc_taps_t  taps;
    integer      bad_count = 0;
    integer      cmp_count = 0;
    integer      vc = 0;
    integer      mc = 0;
    integer      steps = 0;
    integer      i;

    always #2.5 clk_sys = ~clk_sys;

    bcdc_counter #(.OSC_DIV(4), .ADV_STEPS(2)) i_bcdc_counter (
        .clk_sys(clk_sys), .rst_b(rst_b), .extClockSelect(extClockSelect),
        .extClock(extClock), .logicMode(logicMode), .singleStep(singleStep),
        .advanceStep(advanceStep), .varEnable(varEnable),
        .varCarryIn(varCarryIn), .varZero(varZero),
        .thumbwheelInhibit(thumbwheelInhibit), .thumbwheel(thumbwheel),
        .patchedValue(patchedValue), .selectableCarryOut(selectableCarryOut),
        .varHundredCarry(varHundredCarry), .monitor(monitor),
        .mulEnable(mulEnable), .mulCarryIn(mulCarryIn), .mulZero(mulZero),
        .taps(taps));

    bcdc_patch_logic i_bcdc_patch_logic (
        .clk_sys(clk_sys), .rst_b(rst_b), .reroll(reroll),
        .patchedValue(patchedValue), .mulEnable(mulEnable),
        .mulCarryIn(mulCarryIn), .mulZero(mulZero));

    // ------------------------------------------------------------
    // expectation helpers
    // ------------------------------------------------------------
    function automatic bcdc_value_t bcd(input integer n);
        bcd = {4'(n / 10), 4'(n % 10)};
    endfunction

    function automatic integer num(input bcdc_value_t v);
        num = v.tens * 10 + v.units;
    endfunction

    function automatic bcdc_taps_t tapsOf(input integer n, input logic ci);
        tapsOf = {n % 2 == 1, n % 5 == 4, n % 10 == 9, n % 20 == 19,
                  n % 50 == 49, n == 99};
        if (ci !== 1'b1)
            tapsOf = '0;
    endfunction

    task automatic cmpVal(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cmpFlag(input logic got, input logic exp);
        cmp_count++;
        if (got !== exp)
        begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wrap_up();
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic check();
        integer     s;
        bcdc_taps_t t;
        s = num(thumbwheelInhibit ? patchedValue : thumbwheel);
        s = (s + 99) % 100;
        t = tapsOf(mc, mulCarryIn);
        cmpVal(monitor, bcd(vc));
        cmpFlag(selectableCarryOut, varCarryIn && vc == s);
        cmpFlag(varHundredCarry, varCarryIn && vc == 99);
        cmpVal({2'b00, taps}, {2'b00, t});
    endtask

    // one external logic clock edge, then the model steps
    task automatic tick();
        reroll = 1'b1;
        @(posedge clk_sys) #1 reroll = 1'b0;
        extClock = 1'b1;
        repeat (6) @(posedge clk_sys);
        #1 extClock = 1'b0;
        repeat (6) @(posedge clk_sys);
        #1;
        if (logicMode == BCDC_MODE_RUN || steps > 0)
        begin
            if (varZero)
                vc = 0;
            else if (varEnable && varCarryIn)
                vc = (vc + 1) % 100;
            if (mulZero)
                mc = 0;
            else if (mulEnable && mulCarryIn)
                mc = (mc + 1) % 100;
            if (logicMode != BCDC_MODE_RUN)
                steps--;
        end
        check();
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        repeat (8) @(posedge clk_sys);
        #1 rst_b = 1'b1;
        cmpVal(monitor, 8'h00);
        for (i = 0; i < 250; i++)
        begin
            varEnable = i % 7 != 3;
            varCarryIn = i % 11 != 5;
            varZero = i == 50 || i == 240;
            thumbwheelInhibit = i[2];
            thumbwheel = bcd(i * 13 % 100);
            tick();
        end
        thumbwheelInhibit = 1'b0;
        thumbwheel = bcd((vc + 1) % 100);
        #1 check();
        varEnable = 1'b1;
        varCarryIn = 1'b1;
        varZero = 1'b0;
        logicMode = BCDC_MODE_STOP;
        tick();
        singleStep = 1'b1;
        repeat (4) @(posedge clk_sys);
        #1 singleStep = 1'b0;
        steps = 1;
        tick();
        tick();
        advanceStep = 1'b1;
        repeat (4) @(posedge clk_sys);
        #1 advanceStep = 1'b0;
        steps = 2;
        for (i = 0; i < 3; i++)
            tick();
        logicMode = BCDC_MODE_LOAD;
        repeat (3) @(posedge clk_sys);
        #1 vc = 0;
        mc = 0;
        check();
        logicMode = BCDC_MODE_RUN;
        extClockSelect = 1'b0;
        repeat (40) @(posedge clk_sys);
        #1 cmpVal(monitor, bcd(40 / 4));
        wrap_up();
    end

    initial
    begin
        #100000;
        bad_count++;
        wrap_up();
    end
endmodule

`default_nettype wire
